// >>> rtl/rtcvw_top.sv
`timescale 1ns/1ps
module rtcvw_top #(
    parameter int ADDR_WIDTH = 8
) (
    // apb clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb request
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    // apb answer
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr
);
    import rtcvw_pkg::*;

    localparam int OFF_WIDTH      = $bits(RTCVW_CTRL_OFF);
    localparam int SEL_WIDTH      = $bits(RTCVW_TSEL_MIN_SEC);
    localparam int VALUE_WIDTH    = $bits(RTCVW_WORD_RESET);
    localparam int MIN_ADDR_WIDTH = 4;
    localparam int MAX_ADDR_WIDTH = 32;

    // the status offset needs four address bits; wider buses decode in full
    if (ADDR_WIDTH < MIN_ADDR_WIDTH || ADDR_WIDTH > MAX_ADDR_WIDTH) begin : g_addr_width_check
        $error("rtcvw_top: ADDR_WIDTH outside the supported range");
    end

    logic                   clock_write_unlock;
    logic [SEL_WIDTH-1:0]   time_window_select;
    logic [SEL_WIDTH-1:0]   alarm_window_select;
    logic                   next_unlock;
    logic [SEL_WIDTH-1:0]   next_tsel;
    logic [SEL_WIDTH-1:0]   next_asel;
    logic                   locked_write_seen;
    logic                   next_locked_seen;
    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;
    logic                   setup;
    logic                   hit_ctrl;
    logic                   hit_time;
    logic                   hit_alarm;
    logic                   hit_status;
    logic                   ctrl_wr;
    logic                   status_wr;
    logic                   time_wr;
    logic                   alarm_wr;
    logic                   locked_value_wr;
    logic [VALUE_WIDTH-1:0] time_minutes_seconds_value;
    logic [VALUE_WIDTH-1:0] alarm_month_day_value;
    logic [VALUE_WIDTH-1:0] time_value_window;
    logic [VALUE_WIDTH-1:0] alarm_value_window;

    // offsets zero-extend or cut to the bus width on purpose
    function automatic logic addr_hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [OFF_WIDTH-1:0]  offset
    );
        return addr == ADDR_WIDTH'(offset);
    endfunction

    // a window shows its word only under the matching selection
    function automatic logic [VALUE_WIDTH-1:0] window_view(
        input logic [SEL_WIDTH-1:0]   sel,
        input logic [SEL_WIDTH-1:0]   match,
        input logic [VALUE_WIDTH-1:0] word
    );
        logic [VALUE_WIDTH-1:0] view;
        view = RTCVW_WORD_RESET;
        if (sel == match) begin
            view = word;
        end
        return view;
    endfunction

    function automatic logic [31:0] ctrl_word(
        input logic                 unlock,
        input logic [SEL_WIDTH-1:0] tsel,
        input logic [SEL_WIDTH-1:0] asel
    );
        logic [31:0] word;
        word                              = RTCVW_ZERO_WORD;
        word[RTCVW_UNLOCK_BIT]            = unlock;
        word[RTCVW_TSEL_LSB +: SEL_WIDTH] = tsel;
        word[RTCVW_ASEL_LSB +: SEL_WIDTH] = asel;
        return word;
    endfunction

    // answer on the cycle after setup: one wait-free access phase
    assign setup      = psel && !penable;
    assign hit_ctrl   = addr_hit(paddr, RTCVW_CTRL_OFF);
    assign hit_time   = addr_hit(paddr, RTCVW_TIME_VAL_OFF);
    assign hit_alarm  = addr_hit(paddr, RTCVW_ALARM_VAL_OFF);
    assign hit_status = addr_hit(paddr, RTCVW_STATUS_OFF);

    assign ctrl_wr         = setup && pwrite && hit_ctrl;
    assign status_wr       = setup && pwrite && hit_status;
    assign locked_value_wr = setup && pwrite && (hit_time || hit_alarm) && !clock_write_unlock;

    // value words reached only through their matching selection
    assign time_wr  = setup && pwrite && hit_time && clock_write_unlock
                      && time_window_select == RTCVW_TSEL_MIN_SEC;
    assign alarm_wr = setup && pwrite && hit_alarm && clock_write_unlock
                      && alarm_window_select == RTCVW_ASEL_MTH_DAY;

    rtcvw_word #(
        .MASK (RTCVW_MIN_SEC_MASK)
    ) u_time (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (time_wr),
        .wr_data (pwdata[15:0]),
        .value   (time_minutes_seconds_value)
    );

    rtcvw_word #(
        .MASK (RTCVW_MTH_DAY_MASK)
    ) u_alarm (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (alarm_wr),
        .wr_data (pwdata[15:0]),
        .value   (alarm_month_day_value)
    );

    // other selections are outside this block and read zero
    assign time_value_window  = window_view(time_window_select, RTCVW_TSEL_MIN_SEC,
                                            time_minutes_seconds_value);
    assign alarm_value_window = window_view(alarm_window_select, RTCVW_ASEL_MTH_DAY,
                                            alarm_month_day_value);

    // unlock and window selections
    always_comb begin
        next_unlock = clock_write_unlock;
        next_tsel   = time_window_select;
        next_asel   = alarm_window_select;
        if (ctrl_wr) begin
            next_unlock = pwdata[RTCVW_UNLOCK_BIT];
            next_tsel   = pwdata[RTCVW_TSEL_LSB +: SEL_WIDTH];
            next_asel   = pwdata[RTCVW_ASEL_LSB +: SEL_WIDTH];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_write_unlock  <= 1'b0;
            time_window_select  <= RTCVW_TSEL_MIN_SEC;
            alarm_window_select <= RTCVW_ASEL_MTH_DAY;
        end else begin
            clock_write_unlock  <= next_unlock;
            time_window_select  <= next_tsel;
            alarm_window_select <= next_asel;
        end
    end

    // sticky record of refused value writes; a refusal wins over a clear
    always_comb begin
        next_locked_seen = locked_write_seen;
        if (status_wr) begin
            next_locked_seen = 1'b0;
        end
        if (locked_value_wr) begin
            next_locked_seen = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_write_seen <= 1'b0;
        end else begin
            locked_write_seen <= next_locked_seen;
        end
    end

    // bus answer: pready and pslverr pulse for one cycle, prdata holds
    always_comb begin
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (setup) begin
            next_pready = 1'b1;
            next_prdata = RTCVW_ZERO_WORD;
            if (hit_ctrl) begin
                if (!pwrite) begin
                    next_prdata = ctrl_word(clock_write_unlock, time_window_select, alarm_window_select);
                end
            end else if (hit_time) begin
                if (!pwrite) begin
                    next_prdata[VALUE_WIDTH-1:0] = time_value_window;
                end
            end else if (hit_alarm) begin
                if (!pwrite) begin
                    next_prdata[VALUE_WIDTH-1:0] = alarm_value_window;
                end
            end else if (hit_status) begin
                if (!pwrite) begin
                    next_prdata[RTCVW_STATUS_LOCKED_BIT] = locked_write_seen;
                end
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= RTCVW_ZERO_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule

// >>> rtl/rtcvw_pkg.sv
package rtcvw_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] RTCVW_CTRL_OFF      = 8'h00;
    localparam logic [7:0] RTCVW_TIME_VAL_OFF  = 8'h04;
    localparam logic [7:0] RTCVW_ALARM_VAL_OFF = 8'h08;
    localparam logic [7:0] RTCVW_STATUS_OFF    = 8'h0c;
    // control register fields
    localparam int RTCVW_UNLOCK_BIT    = 0;
    localparam int RTCVW_TSEL_LSB      = 8;
    localparam int RTCVW_ASEL_LSB      = 12;
    // status register fields
    localparam int RTCVW_STATUS_LOCKED_BIT = 0;
    // window selections
    localparam logic [1:0] RTCVW_TSEL_MIN_SEC = 2'h0;
    localparam logic [1:0] RTCVW_ASEL_MTH_DAY = 2'h2;
    // implemented bits of each value word
    localparam logic [15:0] RTCVW_MIN_SEC_MASK = 16'h7f7f;
    localparam logic [15:0] RTCVW_MTH_DAY_MASK = 16'h1f3f;
    localparam logic [15:0] RTCVW_WORD_RESET   = 16'h0000;
    localparam logic [31:0] RTCVW_ZERO_WORD    = 32'h0000_0000;
endpackage

// >>> rtl/rtcvw_word.sv
`timescale 1ns/1ps
// one bcd value word with write gating and read masking
module rtcvw_word #(
    parameter logic [15:0] MASK = 16'hffff
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // write side
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // read side
    output logic [15:0]      value
);
    import rtcvw_pkg::*;

    logic [15:0] store;
    logic [15:0] next_store;

    always_comb begin
        next_store = store;
        if (wr_en) begin
            next_store = wr_data & MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store <= RTCVW_WORD_RESET;
        end else begin
            store <= next_store;
        end
    end

    assign value = store & MASK;
endmodule

// >>> verification/rtcvw_monitor.sv
`timescale 1ns/1ps
module rtcvw_monitor (
    // apb clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb request
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    logic        ul;
    logic [1:0]  ts, as;
    logic [15:0] tw, aw;
    wire st = psel && !penable && pwrite;
    wire rd = psel && penable && pready && !pwrite;
    wire t = paddr == 8'h04;
    wire a = paddr == 8'h08;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow of unlock, selections and stored words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ul, ts, as, tw, aw} <= 37'h2_0000_0000;
        end else if (st) begin
            if (paddr == 8'h00) {as, ts, ul} <= {pwdata[13:12], pwdata[9:8], pwdata[0]};
            if (t && ul && ts == 2'h0) tw <= pwdata[15:0] & 16'h7f7f;
            if (a && ul && as == 2'h2) aw <= pwdata[15:0] & 16'h1f3f;
        end
    end
    property p_tv; rd && t && ts == 2'h0 |-> prdata[15:0] == tw; endproperty
    a_tv: assert property (p_tv) else $error("time word");
    property p_av; rd && a && as == 2'h2 |-> prdata[15:0] == aw; endproperty
    a_av: assert property (p_av) else $error("alarm word");
    property p_tz; rd && t |-> (prdata & ~32'h7f7f) == 0; endproperty
    a_tz: assert property (p_tz) else $error("time zeros");
    property p_az; rd && a |-> (prdata & ~32'h1f3f) == 0; endproperty
    a_az: assert property (p_az) else $error("alarm zeros");
    property p_ts; rd && t && ts != 2'h0 |-> prdata == 0; endproperty
    a_ts: assert property (p_ts) else $error("time select");
    property p_as; rd && a && as != 2'h2 |-> prdata == 0; endproperty
    a_as: assert property (p_as) else $error("alarm select");
    property p_wr; st && (t || a) |=> pready && !pslverr; endproperty
    a_wr: assert property (p_wr) else $error("value write");
    c_lk: cover property (st && t && !ul);
    c_rd: cover property (rd && a);
    c_er: cover property (pready && pslverr);
endmodule

// >>> verification/rtcvw_test.sv
`timescale 1ns/1ps
module rtcvw_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    int          err_total = 0, tests_run = 0, cyc = 0;
    always #2 pclk = ~pclk;
    rtcvw_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic go(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'h0;
    endtask
    task automatic rd(string n, logic [7:0] a, logic [31:0] e);
        go(0, a, 0);
        chk(n, prdata, e);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        rd("ctrl", 8'h00, 32'h2000);
        go(1, 8'h04, 32'h1234);
        rd("time", 8'h04, 32'h0);
        rd("stat", 8'h0c, 32'h1);
        $display("test locked done");
        go(1, 8'h00, 32'h2001);
        go(1, 8'h0c, 32'h0);
        go(1, 8'h04, 32'hffff_ffff);
        rd("time", 8'h04, 32'h7f7f);
        go(1, 8'h04, 32'h5959);
        rd("time", 8'h04, 32'h5959);
        go(1, 8'h08, 32'hffff_ffff);
        rd("alarm", 8'h08, 32'h1f3f);
        go(1, 8'h08, 32'h1231);
        rd("alarm", 8'h08, 32'h1231);
        go(1, 8'h00, 32'h3101);
        go(1, 8'h04, 32'h0);
        go(1, 8'h08, 32'h0);
        rd("time", 8'h04, 32'h0);
        rd("alarm", 8'h08, 32'h0);
        rd("stat", 8'h0c, 32'h0);
        $display("test unlocked done");
        go(1, 8'h00, 32'h2000);
        go(1, 8'h04, 32'h0);
        go(1, 8'h08, 32'h0);
        rd("time", 8'h04, 32'h5959);
        rd("alarm", 8'h08, 32'h1231);
        rd("stat", 8'h0c, 32'h1);
        rd("bad", 8'h10, 32'h0);
        chk("err", pslverr, 32'h1);
        $display("test relock done");
        close_out();
    end
endmodule
bind rtcvw_top rtcvw_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata,
    .prdata);
